// >>> rtl/bbfx_pkg.sv
// Purpose: constants and types for the branch, bit and flag execution unit
// Assumes: 8-bit status word, flags at their usual bit order i t h s v n z c
// Notes:
// Overview of operation
// - unsigned-ge branch taken when carry clear; unsigned-lt when set; flags kept.
// - negative branch taken when n is one, positive branch when zero.
// - signed-ge taken when n xor v is zero, signed-lt when one.
// - halfcarry branches taken on h set or clear, no flag change.
// - transfer branches taken on t set or clear.
// - overflow branches taken on v set or clear, no flag change.
// - io bit set forces bit b of port p high in two cycles.
// - io bit clear forces bit b of port p low in two cycles.
// - logical left shift inserts zero at bit 0; z c n v updated.
// - logical right shift inserts zero at bit 7; z c n v updated.
// - rotate left puts old carry in bit 0, old bit 7 to carry.
// - rotate right puts old carry in bit 7, old bit 0 to carry.
// - arithmetic right shift keeps bit 7; z c n v updated.
// - bit store copies register bit b into t only.
// - bit load copies t into register bit b, flags kept.
// - global irq on and off write the i flag in one cycle.
// - dedicated instructions set or clear the s flag only.
// - dedicated instructions set or clear the v flag only.
// - dedicated instructions set or clear the h flag only.
package bbfx_pkg;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam int          BRANCH_TAKEN_CYCLES = 2;
  localparam int          IO_BIT_CYCLES       = 2;
  // axi register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_OPER   = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_WREG   = 8'h10;
  localparam logic [7:0] OFS_IOREG  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    OP_NOP, OP_BR_UGE, OP_BR_ULT, OP_BR_NEG, OP_BR_POS, OP_BR_SGE, OP_BR_SLT,
    OP_BR_HS, OP_BR_HC, OP_BR_TS, OP_BR_TC, OP_BR_VS, OP_BR_VC,
    OP_IO_SET, OP_IO_CLR, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_SHRA, OP_SWAP,
    OP_FLAG_SET, OP_FLAG_CLR, OP_BIT_TO_T, OP_T_TO_BIT
  } bbfx_op_type;
endpackage : bbfx_pkg

// >>> rtl/bbfx_exec.sv
// Purpose: executes branch, bit, shift and flag instructions from axi commands
// Assumes: one instruction at a time, issued by a write to the command register
// Notes: a busy bit shows a second cycle in progress
`timescale 1ns/1ps
`default_nettype none
module bbfx_exec (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [7:0]  status_flag_register,
  output var  logic [15:0] pc_out
);
  // internal state
  logic [7:0]  flags_reg;
  logic [15:0] pc_reg;
  logic [7:0]  wreg_reg;
  logic [7:0]  io_reg;
  logic [15:0] oper_reg;
  logic        busy_reg;
  logic [15:0] pc_target_reg;
  logic        pend_io_reg;
  logic [7:0]  io_next_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  aw_reg;
  logic [31:0] w_reg;
  logic [3:0]  ws_reg;
  logic        wr_go;
  logic        cmd_go;
  logic [4:0]  cmd_op;
  logic [2:0]  bsel;
  logic        cond;
  logic        taken;
  logic [7:0]  res;
  logic [7:0]  flags_next;
  logic        shift_op;
  // decode
  logic        io_op;
  logic [15:0] br_ofs;
  logic [7:0]  rd_addr;
  logic        wr_flags;
  logic        wr_wreg;
  logic        wr_io;
  logic        wr_oper_lo;
  logic        wr_oper_hi;

  function automatic logic [7:0] shift_flags(input logic [7:0] s, input logic [7:0] r, input logic c);
    logic [7:0] f;
    f = s;
    f[bbfx_pkg::FLAG_C] = c;
    f[bbfx_pkg::FLAG_Z] = (r == 8'h00);
    f[bbfx_pkg::FLAG_N] = r[7];
    f[bbfx_pkg::FLAG_V] = r[7] ^ c;
    f[bbfx_pkg::FLAG_S] = r[7] ^ (r[7] ^ c);
    return f;
  endfunction : shift_flags

  // register write strobe for one offset and byte lane
  function automatic logic lane_hit(
    input logic       go,
    input logic [7:0] addr,
    input logic [7:0] ofs,
    input logic       lane
  );
    return go && (addr == ofs) && lane;
  endfunction : lane_hit

  // offsets beyond the last register answer with an error
  function automatic logic addr_mapped(input logic [7:0] addr);
    return addr <= bbfx_pkg::OFS_STATUS;
  endfunction : addr_mapped

  // read data mux
  function automatic logic [31:0] read_word(
    input logic [7:0]  addr,
    input logic [15:0] oper,
    input logic [7:0]  flags,
    input logic [15:0] pc,
    input logic [7:0]  wreg,
    input logic [7:0]  io,
    input logic        busy
  );
    logic [31:0] d;
    d = 32'h00000000;
    unique case (addr)
      bbfx_pkg::OFS_CMD:    d = 32'h00000000;
      bbfx_pkg::OFS_OPER:   d = {16'h0000, oper};
      bbfx_pkg::OFS_FLAGS:  d = {24'h000000, flags};
      bbfx_pkg::OFS_PC:     d = {16'h0000, pc};
      bbfx_pkg::OFS_WREG:   d = {24'h000000, wreg};
      bbfx_pkg::OFS_IOREG:  d = {24'h000000, io};
      bbfx_pkg::OFS_STATUS: d = {31'h00000000, busy};
      default:              d = 32'h00000000;
    endcase
    return d;
  endfunction : read_word

  // write channel capture, either order
  assign wr_go  = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign cmd_go = wr_go && (aw_reg == bbfx_pkg::OFS_CMD) && ws_reg[0] && !busy_reg;
  assign cmd_op = w_reg[4:0];
  assign bsel   = oper_reg[2:0];
  assign io_op  = (cmd_op == bbfx_pkg::OP_IO_SET) || (cmd_op == bbfx_pkg::OP_IO_CLR);
  assign br_ofs = {{9{oper_reg[6]}}, oper_reg[6:0]};
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  // register write strobes
  assign wr_flags   = lane_hit(wr_go, aw_reg, bbfx_pkg::OFS_FLAGS, ws_reg[0]);
  assign wr_wreg    = lane_hit(wr_go, aw_reg, bbfx_pkg::OFS_WREG, ws_reg[0]);
  assign wr_io      = lane_hit(wr_go, aw_reg, bbfx_pkg::OFS_IOREG, ws_reg[0]);
  assign wr_oper_lo = lane_hit(wr_go, aw_reg, bbfx_pkg::OFS_OPER, ws_reg[0]);
  assign wr_oper_hi = lane_hit(wr_go, aw_reg, bbfx_pkg::OFS_OPER, ws_reg[1]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_reg        <= 8'h00;
      w_reg         <= 32'h00000000;
      ws_reg        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_reg && !s_axi_awready;
      s_axi_wready  <= !w_got_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_reg     <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_reg     <= s_axi_wdata;
        ws_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bbfx_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(aw_reg) ? bbfx_pkg::RESP_OKAY : bbfx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // branch condition select
  always_comb begin
    unique case (cmd_op)
      bbfx_pkg::OP_BR_UGE: cond = !flags_reg[bbfx_pkg::FLAG_C];
      bbfx_pkg::OP_BR_ULT: cond = flags_reg[bbfx_pkg::FLAG_C];
      bbfx_pkg::OP_BR_NEG: cond = flags_reg[bbfx_pkg::FLAG_N];
      bbfx_pkg::OP_BR_POS: cond = !flags_reg[bbfx_pkg::FLAG_N];
      bbfx_pkg::OP_BR_SGE: cond = !(flags_reg[bbfx_pkg::FLAG_N] ^ flags_reg[bbfx_pkg::FLAG_V]);
      bbfx_pkg::OP_BR_SLT: cond = flags_reg[bbfx_pkg::FLAG_N] ^ flags_reg[bbfx_pkg::FLAG_V];
      bbfx_pkg::OP_BR_HS:  cond = flags_reg[bbfx_pkg::FLAG_H];
      bbfx_pkg::OP_BR_HC:  cond = !flags_reg[bbfx_pkg::FLAG_H];
      bbfx_pkg::OP_BR_TS:  cond = flags_reg[bbfx_pkg::FLAG_T];
      bbfx_pkg::OP_BR_TC:  cond = !flags_reg[bbfx_pkg::FLAG_T];
      bbfx_pkg::OP_BR_VS:  cond = flags_reg[bbfx_pkg::FLAG_V];
      bbfx_pkg::OP_BR_VC:  cond = !flags_reg[bbfx_pkg::FLAG_V];
      default:             cond = 1'b0;
    endcase
  end
  assign taken = cmd_go && cond;

  // shift, rotate, swap and bit results
  always_comb begin
    res        = wreg_reg;
    flags_next = flags_reg;
    shift_op   = 1'b1;
    unique case (cmd_op)
      bbfx_pkg::OP_SHL: begin
        res        = {wreg_reg[6:0], 1'b0};
        flags_next = shift_flags(flags_reg, res, wreg_reg[7]);
      end
      bbfx_pkg::OP_SHR: begin
        res        = {1'b0, wreg_reg[7:1]};
        flags_next = shift_flags(flags_reg, res, wreg_reg[0]);
      end
      bbfx_pkg::OP_ROTL: begin
        res        = {wreg_reg[6:0], flags_reg[bbfx_pkg::FLAG_C]};
        flags_next = shift_flags(flags_reg, res, wreg_reg[7]);
      end
      bbfx_pkg::OP_ROTR: begin
        res        = {flags_reg[bbfx_pkg::FLAG_C], wreg_reg[7:1]};
        flags_next = shift_flags(flags_reg, res, wreg_reg[0]);
      end
      bbfx_pkg::OP_SHRA: begin
        res        = {wreg_reg[7], wreg_reg[7:1]};
        flags_next = shift_flags(flags_reg, res, wreg_reg[0]);
      end
      bbfx_pkg::OP_SWAP: res = {wreg_reg[3:0], wreg_reg[7:4]};
      bbfx_pkg::OP_BIT_TO_T: flags_next[bbfx_pkg::FLAG_T] = wreg_reg[bsel];
      bbfx_pkg::OP_T_TO_BIT: res[bsel] = flags_reg[bbfx_pkg::FLAG_T];
      // dedicated set/clear of c z n v s h t i map onto s = 0..7
      bbfx_pkg::OP_FLAG_SET: flags_next[bsel] = 1'b1;
      bbfx_pkg::OP_FLAG_CLR: flags_next[bsel] = 1'b0;
      default: shift_op = 1'b0;
    endcase
  end

  // busy marks the second cycle of a taken branch or io bit op
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg    <= 1'b0;
      pend_io_reg <= 1'b0;
    end else if (busy_reg) begin
      busy_reg    <= 1'b0;
      pend_io_reg <= 1'b0;
    end else if (taken) begin
      busy_reg    <= 1'b1;
    end else if (cmd_go && io_op) begin
      busy_reg    <= 1'b1;
      pend_io_reg <= 1'b1;
    end
  end

  // program counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg        <= bbfx_pkg::PC_RESET;
      pc_target_reg <= bbfx_pkg::PC_RESET;
    end else if (busy_reg) begin
      if (!pend_io_reg) begin
        pc_reg <= pc_target_reg;
      end
    end else if (taken) begin
      pc_target_reg <= 16'(pc_reg + br_ofs + 16'h0001);
    end else if (cmd_go && !io_op) begin
      pc_reg <= 16'(pc_reg + 16'h0001);
    end
  end

  // io staging, value to land on the second cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_next_reg <= 8'h00;
    end else if (!busy_reg && cmd_go && io_op) begin
      io_next_reg       <= io_reg;
      io_next_reg[bsel] <= (cmd_op == bbfx_pkg::OP_IO_SET);
    end
  end

  // io register, written on second cycle of bit set/clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_reg <= 8'h00;
    end else if (busy_reg && pend_io_reg) begin
      io_reg <= io_next_reg;
    end else if (wr_io) begin
      io_reg <= w_reg[7:0];
    end
  end

  // status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= bbfx_pkg::FLAGS_RESET;
    end else if (cmd_go && shift_op) begin
      flags_reg <= flags_next;
    end else if (wr_flags) begin
      flags_reg <= w_reg[7:0];
    end
  end

  // working register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreg_reg <= 8'h00;
    end else if (cmd_go && shift_op) begin
      wreg_reg <= res;
    end else if (wr_wreg) begin
      wreg_reg <= w_reg[7:0];
    end
  end

  // operand register, two byte lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oper_reg <= 16'h0000;
    end else begin
      if (wr_oper_lo) begin
        oper_reg[7:0] <= w_reg[7:0];
      end
      if (wr_oper_hi) begin
        oper_reg[15:8] <= w_reg[15:8];
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= bbfx_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word(rd_addr, oper_reg, flags_reg, pc_reg, wreg_reg, io_reg, busy_reg);
        s_axi_rresp  <= addr_mapped(rd_addr) ? bbfx_pkg::RESP_OKAY : bbfx_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // registered copies of internal state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_flag_register <= bbfx_pkg::FLAGS_RESET;
      pc_out               <= bbfx_pkg::PC_RESET;
    end else begin
      status_flag_register <= flags_reg;
      pc_out               <= pc_reg;
    end
  end
endmodule : bbfx_exec
`default_nettype wire

// >>> tb/bbfx_chk.sv
// Purpose: port checker for bbfx_exec
// Assumes: one command at a time
// Notes: bind at the foot
`timescale 1ns/1ps
`default_nettype none
module bbfx_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  status_flag_register,
  input wire logic [15:0] pc_out
);
  logic [7:0]  aw_reg, sb_reg, sf, msk;
  logic [6:0]  w_reg, k_reg;
  logic [15:0] pb_reg;
  logic [4:0]  op;
  assign sf  = status_flag_register;
  assign op  = w_reg[4:0];
  assign msk = 8'h01 << k_reg[2:0];
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_reg <= s_axi_awaddr;
  end
  // snapshot of flags and pc as a command is handed over
  always_ff @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) begin
      w_reg  <= s_axi_wdata[6:0];
      sb_reg <= sf;
      pb_reg <= pc_out;
    end
  end
  always_ff @(posedge aclk) begin
    if ($rose(s_axi_bvalid) && aw_reg == bbfx_pkg::OFS_OPER) k_reg <= w_reg;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence go_s;
    $rose(s_axi_bvalid) && aw_reg == bbfx_pkg::OFS_CMD;
  endsequence
  a_reset_clear: assert property ($rose(aresetn) |-> pc_out == 16'h0000 && sf == 8'h00)
    else $error("outputs not clear");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_flags_kept: assert property (
    go_s ##0 op inside {[1:14], 20, 24} |-> ##1 (sf == sb_reg) [*3])
    else $error("flags changed");
  a_pc_step: assert property (
    go_s ##0 op inside {[15:24]} |-> ##[1:2] pc_out == pb_reg + 16'h0001)
    else $error("pc not stepped");
  a_io_pc_kept: assert property (
    go_s ##0 op inside {13, 14} |-> ##1 (pc_out == pb_reg) [*3])
    else $error("pc moved");
  a_flag_write: assert property (
    go_s ##0 op inside {21, 22} |-> ##[1:2] sf == (op[0] ? sb_reg | msk : sb_reg & ~msk))
    else $error("flag write wrong");
  a_bit_store: assert property (
    go_s ##0 op == 5'd23 |-> ##1 (((sf ^ sb_reg) & 8'hBF) == 8'h00) [*3])
    else $error("bit store touched flags");
  a_shift_flags: assert property (
    go_s ##0 op inside {[15:19]} |-> ##2 sf[3] == (sf[2] ^ sf[0]) && sf[4] == sf[0])
    else $error("shift flags wrong");
endmodule : bbfx_chk
bind bbfx_exec bbfx_chk u_chk (.*);
`default_nettype wire

// >>> tb/bbfx_exec_tb.sv
// Purpose: self-checking bench for bbfx_exec
// Assumes: axi4-lite access, one command at a time
// Notes: fixed-seed random operands plus corners
`timescale 1ns/1ps
`default_nettype none
module bbfx_exec_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, status_flag_register, sv, wv, iv;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] pc_out, pc_m, rd_d;
  logic [6:0]  kv;
  int          fail_count, cmp_count, seed, i, j;
  bbfx_exec dut (.*);
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic to(input int n);
    if (n >= 40) begin
      chk("wait bound", 16'h0000, 16'hFFFF);
      wrap_up();
    end
  endtask : to
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    to(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    rd_d = s_axi_rdata[15:0];
    rr   = s_axi_rresp;
    s_axi_rready <= 1'b0;
    to(n);
  endtask : rd
  // expected {pc, io, flags, wreg} after one instruction
  function automatic logic [39:0] model(input logic [4:0] o, input logic [7:0] s, w, io, input logic [6:0] k);
    logic [5:0]  f;
    logic [7:0]  r;
    logic [15:0] p;
    f = {s[3], s[6], s[5], s[2] ^ s[3], s[2], s[0]};
    p = pc_m + 16'h0001;
    r = w;
    case (o)
      5'd13, 5'd14: begin
        io[k[2:0]] = (o == 5'd13);
        p = pc_m;
      end
      5'd15, 5'd17: {s[0], r} = {w, (o == 5'd17) & s[0]};
      5'd16, 5'd18, 5'd19: {r, s[0]} = {(o == 5'd18) ? s[0] : (o == 5'd19) & w[7], w};
      5'd20: r = {w[3:0], w[7:4]};
      5'd21, 5'd22: s[k[2:0]] = (o == 5'd21);
      5'd23: s[6] = w[k[2:0]];
      5'd24: r[k[2:0]] = s[6];
      default: if (o != 5'd0 && (f[(o - 5'd1) >> 1] ~^ (o inside {2, 3, 6, 7, 9, 11}))) p = p + {{9{k[6]}}, k};
    endcase
    if (o inside {[15:19]}) begin
      s[1] = (r == 8'h00);
      s[2] = r[7];
      s[3] = r[7] ^ s[0];
      s[4] = s[0];
    end
    return {p, io, s, r};
  endfunction : model
  task automatic run(input logic [4:0] o, input logic [7:0] s, w, input logic [6:0] k);
    logic [39:0] e;
    int          n;
    iv = 8'($random(seed));
    e  = model(o, s, w, iv, k);
    wr(bbfx_pkg::OFS_FLAGS, {24'h0, s});
    wr(bbfx_pkg::OFS_WREG, {24'h0, w});
    wr(bbfx_pkg::OFS_IOREG, {24'h0, iv});
    wr(bbfx_pkg::OFS_OPER, {25'h0, k});
    wr(bbfx_pkg::OFS_CMD, {27'h0, o});
    n = 0;
    do begin
      rd(bbfx_pkg::OFS_STATUS);
      n++;
    end while (rd_d[0] !== 1'b0 && n < 40);
    to(n);
    rd(bbfx_pkg::OFS_FLAGS);
    chk("flags", {8'h00, e[15:8]}, rd_d);
    rd(bbfx_pkg::OFS_WREG);
    chk("wreg", {8'h00, e[7:0]}, rd_d);
    rd(bbfx_pkg::OFS_IOREG);
    chk("ioreg", {8'h00, e[23:16]}, rd_d);
    rd(bbfx_pkg::OFS_PC);
    chk("pc", e[39:24], rd_d);
    pc_m = e[39:24];
  endtask : run
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    seed        = 32'hF86B995E;
    pc_m        = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(bbfx_pkg::OFS_FLAGS);
    chk("reset flags", 16'h0000, rd_d);
    rd(bbfx_pkg::OFS_PC);
    chk("reset pc", 16'h0000, rd_d);
    rd(8'h40);
    chk("unmapped resp", {14'h0, bbfx_pkg::RESP_SLVERR}, {14'h0, rr});
    wr(8'h40, 32'h00000000);
    chk("unmapped bresp", {14'h0, bbfx_pkg::RESP_SLVERR}, {14'h0, rr});
    $display("test reset done");
    run(5'd15, 8'h00, 8'h80, 7'h00);
    run(5'd18, 8'h01, 8'h01, 7'h00);
    run(5'd19, 8'h00, 8'h81, 7'h00);
    run(5'd2, 8'h01, 8'h00, 7'h40);
    run(5'd5, 8'h0C, 8'h00, 7'h3F);
    $display("test corners done");
    for (i = 0; i < 8; i++) begin
      run(5'd21, 8'h00, 8'h00, 7'(i));
      run(5'd22, 8'hFF, 8'h00, 7'(i));
    end
    $display("test flag select done");
    for (j = 0; j < 4; j++) begin
      for (i = 0; i < 25; i++) begin
        sv = 8'($random(seed));
        wv = 8'($random(seed));
        kv = 7'($random(seed));
        run(5'(i), sv, wv, kv);
      end
      $display("test random pass %0d done", j);
    end
    wrap_up();
  end
endmodule : bbfx_exec_tb
`default_nettype wire
